// *** logic/ccs_pkg.sv ***
// constants for the clock source select block
package ccs_pkg;

  // ****************************************
  // register indices (byte address = index * 4)
  // ****************************************
  localparam logic [7:0] REG_PLL_DSP_IDX = 8'h0d;
  localparam logic [7:0] REG_DAC_OSR_IDX = 8'h0e;
  localparam logic [7:0] REG_PUMP_IDX = 8'h0f;
  localparam logic [7:0] REG_PIN_IDX = 8'h10;
  localparam logic [7:0] REG_PUMP_PIN_IDX = 8'h11;
  localparam logic [7:0] REG_REF_PIN_IDX = 8'h12;
  localparam logic [7:0] REG_STATUS_IDX = 8'h20;

  // ****************************************
  // field layout and reset values
  // ****************************************
  localparam int SEL_W = 3;
  localparam int REF_LSB = 4;
  localparam int DSP_LSB = 0;
  localparam int DAC_LSB = 4;
  localparam int OSR_LSB = 0;
  localparam int PUMP_LSB = 0;
  localparam int PIN_DSP_LSB = 4;
  localparam int PIN_DAC_LSB = 0;
  localparam int PUMP_PIN_LSB = 4;
  localparam int REF_PIN_LSB = 0;
  localparam int STAT_MASTER_LSB = 4;
  localparam logic [2:0] SEL_RESET = 3'h0;

  // ****************************************
  // source codes
  // ****************************************
  localparam logic [2:0] REF_MCLK = 3'h0;
  localparam logic [2:0] REF_SCLK = 3'h1;
  localparam logic [2:0] REF_OSC = 3'h2;
  localparam logic [2:0] REF_GPIO = 3'h3;
  localparam logic [2:0] DIV_MASTER = 3'h0;
  localparam logic [2:0] DIV_PLL = 3'h1;
  localparam logic [2:0] DIV_OSC = 3'h2;
  localparam logic [2:0] DIV_MCLK = 3'h3;
  localparam logic [2:0] DIV_SCLK = 3'h4;
  localparam logic [2:0] DIV_GPIO = 3'h5;
  localparam logic [2:0] SUB_DAC = 3'h0;
  localparam logic [2:0] SUB_MASTER = 3'h1;
  localparam logic [2:0] SUB_PLL = 3'h2;
  localparam logic [2:0] SUB_OSC = 3'h3;
  localparam logic [2:0] SUB_MCLK = 3'h4;
  localparam logic [2:0] SUB_SCLK = 3'h5;
  localparam logic [2:0] PUMP_GPIO = 3'h6;
  localparam logic [2:0] PIN_GPIO0 = 3'h3;
  localparam logic [2:0] PIN_GPIO2 = 3'h5;

  // ****************************************
  // channel numbering
  // ****************************************
  localparam int CH_REF = 0;
  localparam int CH_DSP = 1;
  localparam int CH_DAC = 2;
  localparam int CH_OSR = 3;
  localparam int CH_PUMP = 4;
  localparam int NUM_CH = 5;

endpackage : ccs_pkg

// *** logic/ccs_src_mux.sv ***
// one registered source multiplexer, unused codes read as muted
`timescale 1ns/1ps
module ccs_src_mux #(
  parameter int SEL_W = 3
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // candidate sources, zero where a code is reserved
  input wire logic [(1 << SEL_W)-1:0] src_vec,
  input wire logic [SEL_W-1:0] sel,
  // selected source
  output logic clk_out
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_out <= 1'b0;
    end else begin
      clk_out <= src_vec[sel];
    end
  end

endmodule : ccs_src_mux

// *** logic/ccs_clock_select.sv ***
// clock source selection with apb register access
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module ccs_clock_select (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // candidate clock sources, sampled on pclk
  input wire logic pll_clk_in,
  input wire logic osc_clk_in,
  input wire logic mclk_in,
  input wire logic sclk_in,
  input wire logic gpio0_in,
  input wire logic gpio2_in,
  // automatic selection status
  input wire logic auto_set_mode,
  input wire logic mclk_present,
  input wire logic master_path_ok,
  // divider inputs
  output logic pll_ref_clk,
  output logic dsp_div_clk,
  output logic dac_div_clk,
  output logic osr_div_clk,
  output logic pump_div_clk
);

  // ****************************************
  // registers
  // ****************************************
  logic [2:0] ref_sel_reg;
  logic [2:0] dsp_sel_reg;
  logic [2:0] dac_sel_reg;
  logic [2:0] osr_sel_reg;
  logic [2:0] pump_sel_reg;
  logic [2:0] dsp_pin_reg;
  logic [2:0] dac_pin_reg;
  logic [2:0] pump_pin_reg;
  logic [2:0] ref_pin_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [7:0] idx;
  logic aligned;
  logic wr_done;
  logic mapped;
  logic [31:0] rd_next;
  logic [2:0] eff_ref;
  logic master_clk;
  logic [7:0] vec [ccs_pkg::NUM_CH];
  logic [2:0] sel [ccs_pkg::NUM_CH];
  logic [ccs_pkg::NUM_CH-1:0] ch_out;

  assign idx = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign wr_done = psel && penable && pready_reg && pwrite;

  // ****************************************
  // apb read decode
  // ****************************************
  always_comb begin
    rd_next = 32'h0;
    mapped = aligned;
    unique case (idx)
      ccs_pkg::REG_PLL_DSP_IDX: begin
        rd_next[ccs_pkg::REF_LSB +: 3] = ref_sel_reg;
        rd_next[ccs_pkg::DSP_LSB +: 3] = dsp_sel_reg;
      end
      ccs_pkg::REG_DAC_OSR_IDX: begin
        rd_next[ccs_pkg::DAC_LSB +: 3] = dac_sel_reg;
        rd_next[ccs_pkg::OSR_LSB +: 3] = osr_sel_reg;
      end
      ccs_pkg::REG_PUMP_IDX: begin
        rd_next[ccs_pkg::PUMP_LSB +: 3] = pump_sel_reg;
      end
      ccs_pkg::REG_PIN_IDX: begin
        rd_next[ccs_pkg::PIN_DSP_LSB +: 3] = dsp_pin_reg;
        rd_next[ccs_pkg::PIN_DAC_LSB +: 3] = dac_pin_reg;
      end
      ccs_pkg::REG_PUMP_PIN_IDX: begin
        rd_next[ccs_pkg::PUMP_PIN_LSB +: 3] = pump_pin_reg;
      end
      ccs_pkg::REG_REF_PIN_IDX: begin
        rd_next[ccs_pkg::REF_PIN_LSB +: 3] = ref_pin_reg;
      end
      ccs_pkg::REG_STATUS_IDX: begin
        rd_next[2:0] = eff_ref;
        rd_next[ccs_pkg::STAT_MASTER_LSB] = master_path_ok;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
    if (!aligned) begin
      rd_next = 32'h0;
    end
  end

  // no wait states: answer raised in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= psel && !penable;
      if (psel && !penable) begin
        prdata_reg <= pwrite ? 32'h0 : rd_next;
        pslverr_reg <= !mapped;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // ****************************************
  // select registers, written straight through
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_sel_reg <= ccs_pkg::SEL_RESET;
      dsp_sel_reg <= ccs_pkg::SEL_RESET;
      dac_sel_reg <= ccs_pkg::SEL_RESET;
      osr_sel_reg <= ccs_pkg::SEL_RESET;
      pump_sel_reg <= ccs_pkg::SEL_RESET;
    end else if (wr_done && aligned) begin
      if (idx == ccs_pkg::REG_PLL_DSP_IDX) begin
        ref_sel_reg <= pwdata[ccs_pkg::REF_LSB +: 3];
        dsp_sel_reg <= pwdata[ccs_pkg::DSP_LSB +: 3];
      end
      if (idx == ccs_pkg::REG_DAC_OSR_IDX) begin
        dac_sel_reg <= pwdata[ccs_pkg::DAC_LSB +: 3];
        osr_sel_reg <= pwdata[ccs_pkg::OSR_LSB +: 3];
      end
      if (idx == ccs_pkg::REG_PUMP_IDX) begin
        pump_sel_reg <= pwdata[ccs_pkg::PUMP_LSB +: 3];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsp_pin_reg <= ccs_pkg::SEL_RESET;
      dac_pin_reg <= ccs_pkg::SEL_RESET;
      pump_pin_reg <= ccs_pkg::SEL_RESET;
      ref_pin_reg <= ccs_pkg::SEL_RESET;
    end else if (wr_done && aligned) begin
      if (idx == ccs_pkg::REG_PIN_IDX) begin
        dsp_pin_reg <= pwdata[ccs_pkg::PIN_DSP_LSB +: 3];
        dac_pin_reg <= pwdata[ccs_pkg::PIN_DAC_LSB +: 3];
      end
      if (idx == ccs_pkg::REG_PUMP_PIN_IDX) begin
        pump_pin_reg <= pwdata[ccs_pkg::PUMP_PIN_LSB +: 3];
      end
      if (idx == ccs_pkg::REG_REF_PIN_IDX) begin
        ref_pin_reg <= pwdata[ccs_pkg::REF_PIN_LSB +: 3];
      end
    end
  end

  // ****************************************
  // source vectors
  // ****************************************
  function automatic logic pin_pick(input logic [2:0] code,
                                    input logic g0, input logic g2);
    logic r;
    r = 1'b0;
    if (code == ccs_pkg::PIN_GPIO0) begin
      r = g0;
    end else if (code == ccs_pkg::PIN_GPIO2) begin
      r = g2;
    end
    return r;
  endfunction : pin_pick

  // master clock falls back to the oscillator on its own
  assign master_clk = master_path_ok ? pll_clk_in : osc_clk_in;
  // auto-set mode picks mclk when present, else the bit clock
  assign eff_ref = auto_set_mode ?
    (mclk_present ? ccs_pkg::REF_MCLK : ccs_pkg::REF_SCLK) :
    ref_sel_reg;

  always_comb begin
    for (int c = 0; c < ccs_pkg::NUM_CH; c++) begin
      vec[c] = 8'h00;
    end
    vec[ccs_pkg::CH_REF][ccs_pkg::REF_MCLK] = mclk_in;
    vec[ccs_pkg::CH_REF][ccs_pkg::REF_SCLK] = sclk_in;
    vec[ccs_pkg::CH_REF][ccs_pkg::REF_OSC] = osc_clk_in;
    vec[ccs_pkg::CH_REF][ccs_pkg::REF_GPIO] =
      pin_pick(ref_pin_reg, gpio0_in, gpio2_in);
    vec[ccs_pkg::CH_DSP][ccs_pkg::DIV_MASTER] = master_clk;
    vec[ccs_pkg::CH_DSP][ccs_pkg::DIV_PLL] = pll_clk_in;
    vec[ccs_pkg::CH_DSP][ccs_pkg::DIV_OSC] = osc_clk_in;
    vec[ccs_pkg::CH_DSP][ccs_pkg::DIV_MCLK] = mclk_in;
    vec[ccs_pkg::CH_DSP][ccs_pkg::DIV_SCLK] = sclk_in;
    vec[ccs_pkg::CH_DSP][ccs_pkg::DIV_GPIO] =
      pin_pick(dsp_pin_reg, gpio0_in, gpio2_in);
    vec[ccs_pkg::CH_DAC] = vec[ccs_pkg::CH_DSP];
    vec[ccs_pkg::CH_DAC][ccs_pkg::DIV_GPIO] =
      pin_pick(dac_pin_reg, gpio0_in, gpio2_in);
    vec[ccs_pkg::CH_OSR][ccs_pkg::SUB_DAC] = dac_div_clk;
    vec[ccs_pkg::CH_OSR][ccs_pkg::SUB_MASTER] = master_clk;
    vec[ccs_pkg::CH_OSR][ccs_pkg::SUB_PLL] = pll_clk_in;
    vec[ccs_pkg::CH_OSR][ccs_pkg::SUB_OSC] = osc_clk_in;
    vec[ccs_pkg::CH_OSR][ccs_pkg::SUB_MCLK] = mclk_in;
    vec[ccs_pkg::CH_OSR][ccs_pkg::SUB_SCLK] = sclk_in;
    vec[ccs_pkg::CH_PUMP] = vec[ccs_pkg::CH_OSR];
    vec[ccs_pkg::CH_PUMP][ccs_pkg::PUMP_GPIO] =
      pin_pick(pump_pin_reg, gpio0_in, gpio2_in);
  end

  assign sel[ccs_pkg::CH_REF] = eff_ref;
  assign sel[ccs_pkg::CH_DSP] = dsp_sel_reg;
  assign sel[ccs_pkg::CH_DAC] = dac_sel_reg;
  assign sel[ccs_pkg::CH_OSR] = osr_sel_reg;
  assign sel[ccs_pkg::CH_PUMP] = pump_sel_reg;

  // ****************************************
  // registered multiplexers, one per divider
  // ****************************************
  for (genvar c = 0; c < ccs_pkg::NUM_CH; c++) begin : g_ch
    ccs_src_mux #(
      .SEL_W(ccs_pkg::SEL_W)
    ) u_mux (
      .pclk(pclk),
      .presetn(presetn),
      .src_vec(vec[c]),
      .sel(sel[c]),
      .clk_out(ch_out[c])
    );
  end

  assign pll_ref_clk = ch_out[ccs_pkg::CH_REF];
  assign dsp_div_clk = ch_out[ccs_pkg::CH_DSP];
  assign dac_div_clk = ch_out[ccs_pkg::CH_DAC];
  assign osr_div_clk = ch_out[ccs_pkg::CH_OSR];
  assign pump_div_clk = ch_out[ccs_pkg::CH_PUMP];

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ref_mclk;
    !auto_set_mode && ref_sel_reg == 3'h0 |=> pll_ref_clk == $past(mclk_in);
  endproperty
  a_ref_mclk: assert property (p_ref_mclk)
    else $error("pll reference not mclk");

  property p_ref_mute;
    !auto_set_mode && ref_sel_reg > 3'h3 |=> !pll_ref_clk;
  endproperty
  a_ref_mute: assert property (p_ref_mute)
    else $error("reserved reference not muted");

  property p_auto_ref;
    auto_set_mode && mclk_present |=> pll_ref_clk == $past(mclk_in);
  endproperty
  a_auto_ref: assert property (p_auto_ref)
    else $error("auto mode did not override reference");

  property p_ref_gpio;
    !auto_set_mode && ref_sel_reg == 3'h3 && ref_pin_reg == 3'h5
      |=> pll_ref_clk == $past(gpio2_in);
  endproperty
  a_ref_gpio: assert property (p_ref_gpio)
    else $error("gpio reference wrong pin");

  property p_dsp_pll;
    dsp_sel_reg == 3'h1 ##1 dsp_sel_reg == 3'h1
      |-> dsp_div_clk == $past(pll_clk_in);
  endproperty
  a_dsp_pll: assert property (p_dsp_pll)
    else $error("dsp divider not on pll");

  property p_dac_mute;
    dac_sel_reg > 3'h5 |=> !dac_div_clk;
  endproperty
  a_dac_mute: assert property (p_dac_mute)
    else $error("reserved dac source not muted");

  property p_dsp_gpio;
    dsp_sel_reg == 3'h5 && dsp_pin_reg == 3'h3
      |=> dsp_div_clk == $past(gpio0_in);
  endproperty
  a_dsp_gpio: assert property (p_dsp_gpio)
    else $error("dsp gpio source wrong pin");

  property p_pin_mute;
    dac_sel_reg == 3'h5 && dac_pin_reg != 3'h3 && dac_pin_reg != 3'h5
      |=> !dac_div_clk;
  endproperty
  a_pin_mute: assert property (p_pin_mute)
    else $error("reserved pin code not muted");

  property p_osr_dac;
    osr_sel_reg == 3'h0 |=> osr_div_clk == $past(dac_div_clk);
  endproperty
  a_osr_dac: assert property (p_osr_dac)
    else $error("oversampling divider not on dac clock");

  property p_pump_mute;
    pump_sel_reg == 3'h7 |=> !pump_div_clk;
  endproperty
  a_pump_mute: assert property (p_pump_mute)
    else $error("reserved pump source not muted");

  property p_master_osc;
    dsp_sel_reg == 3'h0 && !master_path_ok |=> dsp_div_clk == $past(osc_clk_in);
  endproperty
  a_master_osc: assert property (p_master_osc)
    else $error("master clock did not fall back to oscillator");

  property p_write_live;
    wr_done && paddr == 12'h034 |=> dsp_sel_reg == $past(pwdata[2:0]);
  endproperty
  a_write_live: assert property (p_write_live)
    else $error("select write not applied");

  c_auto: cover property (auto_set_mode && !mclk_present ##1 pll_ref_clk);
  c_gpio_dsp: cover property (dsp_sel_reg == 3'h5 ##1 dsp_div_clk);
  c_pump_gpio: cover property (pump_sel_reg == 3'h6 ##1 pump_div_clk);
  c_err: cover property (pready && pslverr);

endmodule : ccs_clock_select

// *** bench/tb_top.sv ***
// self-checking bench for the clock source select block
`timescale 1ns/1ps
module tb_top;
  // ****************************************
  // stimulus and design
  // ****************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // bit 0 pll, 1 osc, 2 mclk, 3 bit clock, 4 gpio0, 5 gpio2
  logic [5:0] src = 6'h00;
  logic auto_mode = 1'b0;
  logic mclk_ok = 1'b0;
  logic master_ok = 1'b0;
  logic [4:0] outs;
  logic [2:0] ref_c, dsp_c, dac_c, osr_c, pump_c;
  logic [2:0] pin_dsp, pin_dac, pin_pump, pin_ref;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #2.5 pclk = ~pclk;

  ccs_clock_select i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pll_clk_in(src[0]),
    .osc_clk_in(src[1]), .mclk_in(src[2]), .sclk_in(src[3]),
    .gpio0_in(src[4]), .gpio2_in(src[5]), .auto_set_mode(auto_mode),
    .mclk_present(mclk_ok), .master_path_ok(master_ok),
    .pll_ref_clk(outs[4]), .dsp_div_clk(outs[3]), .dac_div_clk(outs[2]),
    .osr_div_clk(outs[1]), .pump_div_clk(outs[0])
  );

  // ****************************************
  // tasks and reference functions
  // ****************************************
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, idx, {24'h000000, d}, rd, err);
    chk("write error", {31'h0, err}, 32'h0);
  endtask : wr

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp,
                       input logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(1'b0, idx, 32'h0, rd, err);
    chk("read data", rd, exp);
    chk("read error", {31'h0, err}, {31'h0, exp_err});
  endtask : rdchk

  task automatic set_sel(input logic [2:0] r, input logic [2:0] d,
                         input logic [2:0] a, input logic [2:0] o,
                         input logic [2:0] p);
    ref_c = r; dsp_c = d; dac_c = a; osr_c = o; pump_c = p;
    wr(ccs_pkg::REG_PLL_DSP_IDX, {1'b0, r, 1'b0, d});
    wr(ccs_pkg::REG_DAC_OSR_IDX, {1'b0, a, 1'b0, o});
    wr(ccs_pkg::REG_PUMP_IDX, {5'h00, p});
  endtask : set_sel

  task automatic set_pins(input logic [2:0] d, input logic [2:0] a,
                          input logic [2:0] p, input logic [2:0] r);
    pin_dsp = d; pin_dac = a; pin_pump = p; pin_ref = r;
    wr(ccs_pkg::REG_PIN_IDX, {1'b0, d, 1'b0, a});
    wr(ccs_pkg::REG_PUMP_PIN_IDX, {1'b0, p, 4'h0});
    wr(ccs_pkg::REG_REF_PIN_IDX, {5'h00, r});
  endtask : set_pins

  function automatic logic pin_of(input logic [2:0] p);
    return (p == 3'h3) ? src[4] : ((p == 3'h5) ? src[5] : 1'b0);
  endfunction : pin_of

  function automatic logic main_of(input logic [2:0] c, input logic [2:0] p);
    case (c)
      3'h0: return master_ok ? src[0] : src[1];
      3'h1: return src[0];
      3'h2: return src[1];
      3'h3: return src[2];
      3'h4: return src[3];
      3'h5: return pin_of(p);
      default: return 1'b0;
    endcase
  endfunction : main_of

  function automatic logic sub_of(input logic [2:0] c, input logic [2:0] p,
                                  input logic g);
    if (c == 3'h0) return main_of(dac_c, pin_dac);
    if (c == 3'h6) return g ? pin_of(p) : 1'b0;
    if (c == 3'h7) return 1'b0;
    return main_of(c - 3'h1, 3'h0);
  endfunction : sub_of

  function automatic logic [4:0] expect_outs();
    logic r;
    if (auto_mode) r = mclk_ok ? src[2] : src[3];
    else if (ref_c == 3'h0) r = src[2];
    else if (ref_c == 3'h1) r = src[3];
    else if (ref_c == 3'h2) r = src[1];
    else if (ref_c == 3'h3) r = pin_of(pin_ref);
    else r = 1'b0;
    return {r, main_of(dsp_c, pin_dsp), main_of(dac_c, pin_dac),
            sub_of(osr_c, 3'h0, 1'b0), sub_of(pump_c, pin_pump, 1'b1)};
  endfunction : expect_outs

  // one source high at a time, master path both ways
  task automatic sweep(input string nm);
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 6; s++) begin
        @(posedge pclk);
        src <= 6'h01 << s;
        master_ok <= m[0];
        repeat (4) @(posedge pclk);
        chk(nm, {27'h0, outs}, {27'h0, expect_outs()});
      end
    end
  endtask : sweep

  // ****************************************
  // timeout and main sequence
  // ****************************************
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  initial begin
    ref_c = 3'h0; dsp_c = 3'h0; dac_c = 3'h0; osr_c = 3'h0; pump_c = 3'h0;
    pin_dsp = 3'h0; pin_dac = 3'h0; pin_pump = 3'h0; pin_ref = 3'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 8'h0d; i <= 8'h12; i++) rdchk(i[7:0], 32'h0, 1'b0);
    sweep("reset selects");
    $display("test reset values done");
    set_sel(3'h7, 3'h7, 3'h7, 3'h7, 3'h7);
    set_pins(3'h7, 3'h7, 3'h7, 3'h7);
    rdchk(ccs_pkg::REG_PLL_DSP_IDX, 32'h77, 1'b0);
    rdchk(ccs_pkg::REG_DAC_OSR_IDX, 32'h77, 1'b0);
    rdchk(ccs_pkg::REG_PUMP_IDX, 32'h07, 1'b0);
    rdchk(ccs_pkg::REG_PIN_IDX, 32'h77, 1'b0);
    rdchk(ccs_pkg::REG_PUMP_PIN_IDX, 32'h70, 1'b0);
    rdchk(ccs_pkg::REG_REF_PIN_IDX, 32'h07, 1'b0);
    rdchk(8'h3f, 32'h0, 1'b1);
    // reset in mid-run must clear every field again
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 8'h0d; i <= 8'h12; i++) rdchk(i[7:0], 32'h0, 1'b0);
    $display("test register access done");
    set_pins(3'h3, 3'h5, 3'h5, 3'h3);
    for (int c = 0; c < 8; c++) begin
      set_sel(c[2:0], c[2:0], c[2:0], c[2:0], c[2:0]);
      sweep("source codes");
    end
    $display("test source codes done");
    set_sel(3'h3, 3'h5, 3'h5, 3'h0, 3'h6);
    for (int p = 0; p < 8; p++) begin
      set_pins(p[2:0], p[2:0], p[2:0], p[2:0]);
      sweep("pin codes");
    end
    $display("test pin codes done");
    set_sel(3'h4, 3'h0, 3'h0, 3'h0, 3'h0);
    auto_mode <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      mclk_ok <= k[0];
      sweep("auto mode");
      rdchk(ccs_pkg::REG_STATUS_IDX, {27'h0, master_ok, 3'h0, !mclk_ok}, 1'b0);
    end
    $display("test auto mode done");
    results();
  end
endmodule : tb_top
